// [src/backlight_config_registers.sv]
// Configuration register bank of the backlight driver, offsets 0x00-0x0A.
`timescale 1ns/1ps
// Function
// - Bit0 write of one resets, self-clears
// - Mode field: standby, backlight, flash
// - Mode bit4 disables pulse-input dimming
// - Mode bit2 selects linear brightness map
// - Five-bit full-scale current code, default 10011
// - Current bits 2:0 enable sinks
// - Two-bit switching frequency shift select
// - Boost bit5 selects 500k or 1000k
// - Three-bit overvoltage threshold, default 011
// - Two-bit overcurrent limit, default 10
// - Secondary bit7 enables auto frequency
// - Secondary bit6 selects inductor value
// - Slew rate field in bits 5:3
// - Eleven-bit brightness from high and low
// - Pulse sample rate field, default 24MHz
// - Pulse bit5 selects input polarity
// - Pulse hysteresis equals code in LSBs
// - Pulse deglitch filter select, default 11
// - Four-bit turn on/off ramp fields
// - Three-bit pulse transition ramp field
// - Four-bit serial transition ramp field
// - Address zero returns fixed identification byte
// - Ignore serial commands 2 ms after soft reset
// - Address increments after each data byte
module backlight_config_registers
  import bl_cfg_pkg::*;
#(
  // Arbitrary identification value.
  parameter logic [7:0] IDENTIFICATION_BYTE = 8'hA5,
  parameter int QUIET_CYCLES = SOFT_RESET_QUIET_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_addr_load,
  input wire logic [REG_AW-1:0] i_addr,
  input wire logic i_wr_stb,
  input wire logic [REG_DW-1:0] i_wdata,
  input wire logic i_rd_stb,
  output logic [REG_DW-1:0] o_rdata,
  output logic o_rd_valid,
  output logic o_busy,
  output logic o_soft_reset,
  output cfg_t o_cfg
);
  logic [REG_AW-1:0] ptr;
  logic [31:0] quiet_cnt;
  logic clear_regs;
  logic accept;
  logic [NUM_REGS-1:0] we;
  logic [7:0] r [NUM_REGS];
  logic [7:0] rd_mux;
  logic [7:0] wm [NUM_REGS];

  // Writable-bit masks, applied again on the read path.
  assign wm[0] = 8'h00;
  assign wm[1] = WM_SOFTWARE_RESET;
  assign wm[2] = WM_OPERATING_MODE_CONTROL;
  assign wm[3] = WM_FULL;
  assign wm[4] = WM_FULL;
  assign wm[5] = WM_BOOST_CONTROL_SECONDARY;
  assign wm[6] = WM_FULL;
  assign wm[7] = WM_FULL;
  assign wm[8] = WM_FULL;
  assign wm[9] = WM_FULL;
  assign wm[10] = WM_DIMMING_TRANSITION_RAMP;

  // Every strobe is ignored while the blackout runs.
  // Quiet after soft reset.
  assign accept = !o_busy;

  // The pulse clears every byte, the pointer and the read data.
  // Soft reset request.
  assign clear_regs = i_srst || o_soft_reset;

  // The pulse lasts one cycle, since the byte itself stores nothing.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_soft_reset <= 1'b0;
    end else begin
      o_soft_reset <= accept && i_wr_stb && !i_addr_load &&
                      ptr == OFS_SOFTWARE_RESET && i_wdata[POS_SOFT_RESET];
    end
  end

  // Blackout counter; the window lasts exactly QUIET_CYCLES cycles.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      quiet_cnt <= '0;
      o_busy <= 1'b0;
    end else if (o_soft_reset) begin
      quiet_cnt <= 32'(QUIET_CYCLES - 1);
      o_busy <= 1'b1;
    end else if (quiet_cnt != '0) begin
      quiet_cnt <= quiet_cnt - 32'd1;
    end else begin
      o_busy <= 1'b0;
    end
  end

  // Pointer loads from the address phase and steps after each byte.
  // It wraps from 0xFF back to 0x00.
  always_ff @(posedge i_sys_clk) begin
    if (clear_regs) begin
      ptr <= '0;
    end else if (accept && i_addr_load) begin
      ptr <= i_addr;
    end else if (accept && (i_wr_stb || i_rd_stb)) begin
      ptr <= ptr + 8'h01;
    end
  end

  // One write enable per byte; an address load in the same cycle wins.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_we
      assign we[gi] = accept && i_wr_stb && !i_addr_load &&
                      ptr == 8'(gi);
    end
  endgenerate

  // Address zero stores nothing; its fixed byte comes from the read mux.
  cfg_byte_reg #(
    .RESET_VAL(8'h00),
    .WR_MASK(8'h00)
  ) u_chip_identifier_reg (
    .i_sys_clk(i_sys_clk),
    .i_clear(clear_regs),
    .i_we(we[0]),
    .i_wdata(i_wdata),
    .o_value(r[0])
  );

  cfg_byte_reg #(
    .RESET_VAL(RST_SOFTWARE_RESET),
    .WR_MASK(8'h00)
  ) u_software_reset_reg (
    .i_sys_clk(i_sys_clk),
    .i_clear(clear_regs),
    .i_we(we[1]),
    .i_wdata(i_wdata),
    .o_value(r[1])
  );

  cfg_byte_reg #(
    .RESET_VAL(RST_OPERATING_MODE_CONTROL),
    .WR_MASK(WM_OPERATING_MODE_CONTROL)
  ) u_operating_mode_control_reg (
    .i_sys_clk(i_sys_clk),
    .i_clear(clear_regs),
    .i_we(we[2]),
    .i_wdata(i_wdata),
    .o_value(r[2])
  );

  // The current byte has no reserved bits.
  cfg_byte_reg #(
    .RESET_VAL(RST_STRING_CURRENT_ENABLE),
    .WR_MASK(WM_FULL)
  ) u_string_current_enable_reg (
    .i_sys_clk(i_sys_clk),
    .i_clear(clear_regs),
    .i_we(we[3]),
    .i_wdata(i_wdata),
    .o_value(r[3])
  );

  // The primary boost byte has no reserved bits.
  cfg_byte_reg #(
    .RESET_VAL(RST_BOOST_CONTROL_PRIMARY),
    .WR_MASK(WM_FULL)
  ) u_boost_control_primary_reg (
    .i_sys_clk(i_sys_clk),
    .i_clear(clear_regs),
    .i_we(we[4]),
    .i_wdata(i_wdata),
    .o_value(r[4])
  );

  cfg_byte_reg #(
    .RESET_VAL(RST_BOOST_CONTROL_SECONDARY),
    .WR_MASK(WM_BOOST_CONTROL_SECONDARY)
  ) u_boost_control_secondary_reg (
    .i_sys_clk(i_sys_clk),
    .i_clear(clear_regs),
    .i_we(we[5]),
    .i_wdata(i_wdata),
    .o_value(r[5])
  );

  // The upper bits of the low brightness byte are stored as written.
  cfg_byte_reg #(
    .RESET_VAL(RST_BRIGHTNESS_LOW_BITS),
    .WR_MASK(WM_FULL)
  ) u_brightness_low_bits_reg (
    .i_sys_clk(i_sys_clk),
    .i_clear(clear_regs),
    .i_we(we[6]),
    .i_wdata(i_wdata),
    .o_value(r[6])
  );

  // The high brightness byte has no reserved bits.
  cfg_byte_reg #(
    .RESET_VAL(RST_BRIGHTNESS_HIGH_BITS),
    .WR_MASK(WM_FULL)
  ) u_brightness_high_bits_reg (
    .i_sys_clk(i_sys_clk),
    .i_clear(clear_regs),
    .i_we(we[7]),
    .i_wdata(i_wdata),
    .o_value(r[7])
  );

  // The pulse input byte has no reserved bits.
  cfg_byte_reg #(
    .RESET_VAL(RST_PULSE_INPUT_CONTROL),
    .WR_MASK(WM_FULL)
  ) u_pulse_input_control_reg (
    .i_sys_clk(i_sys_clk),
    .i_clear(clear_regs),
    .i_we(we[8]),
    .i_wdata(i_wdata),
    .o_value(r[8])
  );

  // The sink ramp byte has no reserved bits.
  cfg_byte_reg #(
    .RESET_VAL(RST_SINK_ON_OFF_RAMP),
    .WR_MASK(WM_FULL)
  ) u_sink_on_off_ramp_reg (
    .i_sys_clk(i_sys_clk),
    .i_clear(clear_regs),
    .i_we(we[9]),
    .i_wdata(i_wdata),
    .o_value(r[9])
  );

  cfg_byte_reg #(
    .RESET_VAL(RST_DIMMING_TRANSITION_RAMP),
    .WR_MASK(WM_DIMMING_TRANSITION_RAMP)
  ) u_dimming_transition_ramp_reg (
    .i_sys_clk(i_sys_clk),
    .i_clear(clear_regs),
    .i_we(we[10]),
    .i_wdata(i_wdata),
    .o_value(r[10])
  );

  // Read mux; soft reset bit always reads zero since it self-clears.
  always_comb begin
    rd_mux = 8'h00;
    if (ptr == OFS_CHIP_IDENTIFIER) begin
      rd_mux = IDENTIFICATION_BYTE;
    end else if (ptr < 8'(NUM_REGS)) begin
      rd_mux = r[ptr[3:0]] & wm[ptr[3:0]];
    end else begin
      rd_mux = 8'h00;
    end
  end

  // Read data holds until the next accepted read or a reset.
  always_ff @(posedge i_sys_clk) begin
    if (clear_regs) begin
      o_rdata <= 8'h00;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= accept && i_rd_stb && !i_addr_load;
      if (accept && i_rd_stb && !i_addr_load) begin
        o_rdata <= rd_mux;
      end
    end
  end

  // Decoded configuration outputs, all registered.
  // The outputs lag the bytes by one cycle.
  always_ff @(posedge i_sys_clk) begin
    if (clear_regs) begin
      o_cfg <= '0;
    end else begin
      case (r[2][POS_MODE_LO +: 2])
        2'b00: o_cfg.operating_mode_field <= MODE_STANDBY;
        2'b01: o_cfg.operating_mode_field <= MODE_BACKLIGHT;
        default: o_cfg.operating_mode_field <= MODE_FLASH;
      endcase
      o_cfg.linear_map <= r[2][POS_MAP];
      o_cfg.pulse_dimming_disable <= r[2][POS_PULSE_DISABLE];
      o_cfg.full_scale_current_code <= r[3][POS_FS_LO +: 5];
      o_cfg.sink_three_enable <= r[3][POS_SINK_THREE];
      o_cfg.sink_two_enable <= r[3][POS_SINK_TWO];
      o_cfg.sink_one_enable <= r[3][POS_SINK_ONE];
      o_cfg.frequency_shift_select <= r[4][POS_FREQ_SHIFT_LO +: 2];
      o_cfg.switching_frequency_select <= r[4][POS_SWITCH_FREQ];
      o_cfg.overvoltage_threshold_select <= r[4][POS_OVP_LO +: 3];
      o_cfg.overcurrent_limit_select <= r[4][POS_OCP_LO +: 2];
      o_cfg.auto_frequency_enable <= r[5][POS_AUTO_FREQ];
      o_cfg.inductor_value_select <= r[5][POS_INDUCTOR];
      o_cfg.slew_rate_select <= r[5][POS_SLEW_LO +: 3];
      o_cfg.brightness <= {r[7], r[6][2:0]};
      o_cfg.pulse_sample_rate <= r[8][POS_PSF_LO +: 2];
      o_cfg.pulse_polarity <= r[8][POS_ACT];
      o_cfg.pulse_hysteresis <= r[8][POS_HYS_LO +: 3];
      o_cfg.pulse_deglitch_filter <= r[8][POS_FLT_LO +: 2];
      o_cfg.turn_on_ramp_field <= r[9][POS_ON_LO +: 4];
      o_cfg.turn_off_ramp_field <= r[9][POS_OFF_LO +: 4];
      o_cfg.pulse_transition_ramp_field <= r[10][POS_PTR_LO +: 3];
      o_cfg.serial_transition_ramp_field <= r[10][POS_SER_LO +: 4];
    end
  end
endmodule // backlight_config_registers

// [inc/bl_cfg_pkg.sv]
// Package with register map, field layout and timing for the config bank.
package bl_cfg_pkg;
  localparam int REG_AW = 8;
  localparam int REG_DW = 8;
  localparam int NUM_REGS = 11;
  // Register offsets.
  localparam logic [7:0] OFS_CHIP_IDENTIFIER = 8'h00;
  localparam logic [7:0] OFS_SOFTWARE_RESET = 8'h01;
  localparam logic [7:0] OFS_OPERATING_MODE_CONTROL = 8'h02;
  localparam logic [7:0] OFS_STRING_CURRENT_ENABLE = 8'h03;
  localparam logic [7:0] OFS_BOOST_CONTROL_PRIMARY = 8'h04;
  localparam logic [7:0] OFS_BOOST_CONTROL_SECONDARY = 8'h05;
  localparam logic [7:0] OFS_BRIGHTNESS_LOW_BITS = 8'h06;
  localparam logic [7:0] OFS_BRIGHTNESS_HIGH_BITS = 8'h07;
  localparam logic [7:0] OFS_PULSE_INPUT_CONTROL = 8'h08;
  localparam logic [7:0] OFS_SINK_ON_OFF_RAMP = 8'h09;
  localparam logic [7:0] OFS_DIMMING_TRANSITION_RAMP = 8'h0A;
  // Reset values.
  localparam logic [7:0] RST_SOFTWARE_RESET = 8'h00;
  localparam logic [7:0] RST_OPERATING_MODE_CONTROL = 8'h00;
  localparam logic [7:0] RST_STRING_CURRENT_ENABLE = 8'h9F;
  localparam logic [7:0] RST_BOOST_CONTROL_PRIMARY = 8'h2E;
  localparam logic [7:0] RST_BOOST_CONTROL_SECONDARY = 8'h00;
  localparam logic [7:0] RST_BRIGHTNESS_LOW_BITS = 8'h07;
  localparam logic [7:0] RST_BRIGHTNESS_HIGH_BITS = 8'hFF;
  localparam logic [7:0] RST_PULSE_INPUT_CONTROL = 8'h93;
  localparam logic [7:0] RST_SINK_ON_OFF_RAMP = 8'h44;
  localparam logic [7:0] RST_DIMMING_TRANSITION_RAMP = 8'h00;
  // Writable-bit masks; other bits read zero and ignore writes.
  localparam logic [7:0] WM_SOFTWARE_RESET = 8'h01;
  localparam logic [7:0] WM_OPERATING_MODE_CONTROL = 8'h17;
  localparam logic [7:0] WM_BOOST_CONTROL_SECONDARY = 8'hF8;
  localparam logic [7:0] WM_DIMMING_TRANSITION_RAMP = 8'h7F;
  localparam logic [7:0] WM_FULL = 8'hFF;
  // Field positions.
  localparam int POS_SOFT_RESET = 0;
  localparam int POS_MODE_LO = 0;
  localparam int POS_MAP = 2;
  localparam int POS_PULSE_DISABLE = 4;
  localparam int POS_FS_LO = 3;
  localparam int POS_SINK_ONE = 0;
  localparam int POS_SINK_TWO = 1;
  localparam int POS_SINK_THREE = 2;
  localparam int POS_OCP_LO = 0;
  localparam int POS_OVP_LO = 2;
  localparam int POS_SWITCH_FREQ = 5;
  localparam int POS_FREQ_SHIFT_LO = 6;
  localparam int POS_SLEW_LO = 3;
  localparam int POS_INDUCTOR = 6;
  localparam int POS_AUTO_FREQ = 7;
  localparam int POS_FLT_LO = 0;
  localparam int POS_HYS_LO = 2;
  localparam int POS_ACT = 5;
  localparam int POS_PSF_LO = 6;
  localparam int POS_OFF_LO = 0;
  localparam int POS_ON_LO = 4;
  localparam int POS_SER_LO = 0;
  localparam int POS_PTR_LO = 4;
  // Blackout after a soft reset.
  localparam int CLK_MHZ = 250;
  localparam int SOFT_RESET_QUIET_MS = 2;
  localparam int SOFT_RESET_QUIET_CYC = SOFT_RESET_QUIET_MS * 1000 * CLK_MHZ;

  typedef enum logic [1:0] {
    MODE_STANDBY, MODE_BACKLIGHT, MODE_FLASH
  } op_mode_t;

  typedef struct packed {
    op_mode_t operating_mode_field;
    logic linear_map;
    logic pulse_dimming_disable;
    logic [4:0] full_scale_current_code;
    logic sink_three_enable;
    logic sink_two_enable;
    logic sink_one_enable;
    logic [1:0] frequency_shift_select;
    logic switching_frequency_select;
    logic [2:0] overvoltage_threshold_select;
    logic [1:0] overcurrent_limit_select;
    logic auto_frequency_enable;
    logic inductor_value_select;
    logic [2:0] slew_rate_select;
    logic [10:0] brightness;
    logic [1:0] pulse_sample_rate;
    logic pulse_polarity;
    logic [2:0] pulse_hysteresis;
    logic [1:0] pulse_deglitch_filter;
    logic [3:0] turn_on_ramp_field;
    logic [3:0] turn_off_ramp_field;
    logic [2:0] pulse_transition_ramp_field;
    logic [3:0] serial_transition_ramp_field;
  } cfg_t;
endpackage

// [src/cfg_byte_reg.sv]
// One configuration byte with reset value and writable-bit mask.
`timescale 1ns/1ps
module cfg_byte_reg #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WR_MASK = 8'hFF
) (
  input wire logic i_sys_clk,
  input wire logic i_clear,
  input wire logic i_we,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_value
);
  always_ff @(posedge i_sys_clk) begin
    if (i_clear) begin
      o_value <= RESET_VAL & WR_MASK;
    end else if (i_we) begin
      // Bits outside the mask stay zero.
      o_value <= i_wdata & WR_MASK;
    end
  end
endmodule // cfg_byte_reg

// [sim/backlight_config_monitor.sv]
// Concurrent checks on the ports of the configuration register bank.
`timescale 1ns/1ps
module backlight_config_monitor
  import bl_cfg_pkg::*;
#(
  parameter logic [7:0] IDENTIFICATION_BYTE = 8'hA5,
  parameter int QUIET_CYCLES = 16
) (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_addr_load,
  input wire logic [REG_AW-1:0] i_addr,
  input wire logic i_wr_stb,
  input wire logic [REG_DW-1:0] i_wdata,
  input wire logic i_rd_stb,
  input wire logic [REG_DW-1:0] o_rdata,
  input wire logic o_rd_valid,
  input wire logic o_busy,
  input wire logic o_soft_reset,
  input wire cfg_t o_cfg
);
  logic acc_ld;
  logic acc_rd;
  logic acc_wr;
  int busy_len;
  assign acc_ld = i_addr_load && !o_busy && !o_soft_reset;
  assign acc_rd = i_rd_stb && !i_addr_load && !o_busy && !o_soft_reset;
  assign acc_wr = i_wr_stb && !i_addr_load && !o_busy && !o_soft_reset;
  // Counts how long the blackout has lasted so far.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst || !o_busy) busy_len <= 0;
    else busy_len <= busy_len + 1;
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  sequence ptr_read(lo, hi);
    acc_ld && i_addr >= lo && i_addr <= hi ##1 acc_rd;
  endsequence
  sequence mode_write;
    acc_ld && i_addr == OFS_OPERATING_MODE_CONTROL ##1 acc_wr;
  endsequence
  sequence no_change;
    (!i_wr_stb && !o_busy && !o_soft_reset)[*3];
  endsequence
  a_read_valid: assert property (acc_rd |=> o_rd_valid)
    else $error("read strobe not answered");
  a_busy_mute: assert property (o_busy |=> !o_rd_valid)
    else $error("read answered during blackout");
  a_soft_busy: assert property (o_soft_reset |-> ##[0:1] o_busy)
    else $error("no blackout after soft reset");
  a_busy_length: assert property ($fell(o_busy) |->
    busy_len >= QUIET_CYCLES - 1 && busy_len <= QUIET_CYCLES + 1)
    else $error("blackout length wrong");
  a_soft_single: assert property (o_soft_reset |=> !o_soft_reset)
    else $error("soft reset pulse not cleared");
  a_soft_cause: assert property (o_soft_reset |->
    $past(i_wr_stb && i_wdata[0] && !o_busy))
    else $error("soft reset without write of one");
  a_id_read: assert property (ptr_read(8'h00, 8'h00) |=>
    o_rd_valid && o_rdata == IDENTIFICATION_BYTE)
    else $error("identification byte wrong");
  a_unmapped_zero: assert property (ptr_read(8'h0B, 8'hFF) |=>
    o_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_mode_decode: assert property (o_cfg.operating_mode_field != 2'h3)
    else $error("mode decode out of range");
  a_mode_write: assert property (mode_write |-> ##2 (
    o_cfg.operating_mode_field == ($past(i_wdata[1], 2) ? MODE_FLASH :
    ($past(i_wdata[0], 2) ? MODE_BACKLIGHT : MODE_STANDBY))))
    else $error("mode field does not follow write");
  a_cfg_hold: assert property (no_change |=> $stable(o_cfg))
    else $error("configuration changed without write");
endmodule // backlight_config_monitor
bind backlight_config_registers backlight_config_monitor #(
  .IDENTIFICATION_BYTE(IDENTIFICATION_BYTE), .QUIET_CYCLES(QUIET_CYCLES)
) monitor_inst (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
  .i_addr_load(i_addr_load), .i_addr(i_addr), .i_wr_stb(i_wr_stb),
  .i_wdata(i_wdata), .i_rd_stb(i_rd_stb), .o_rdata(o_rdata),
  .o_rd_valid(o_rd_valid), .o_busy(o_busy), .o_soft_reset(o_soft_reset),
  .o_cfg(o_cfg));

// [sim/host_port_model.sv]
// Host side of the register port, with a queue of returned read data.
`timescale 1ns/1ps
module host_port_model (
  input wire logic i_clk,
  input wire logic i_busy,
  input wire logic i_rd_valid,
  input wire logic [7:0] i_rdata,
  output logic o_load,
  output logic [7:0] o_addr,
  output logic o_wr,
  output logic [7:0] o_wdata,
  output logic o_rd
);
  logic polite = 1'h1;
  logic [7:0] rq[$];
  initial {o_load, o_wr, o_rd, o_addr, o_wdata} = '0;
  // Op bits are load, write, read; each stands until the next call.
  task automatic cmd(input logic [2:0] op, input logic [7:0] a, d);
    @(negedge i_clk);
    while (polite && i_busy) @(negedge i_clk);
    {o_load, o_wr, o_rd, o_addr, o_wdata} = {op, a, d};
  endtask
  always @(posedge i_clk) if (i_rd_valid === 1'h1) rq.push_back(i_rdata);
endmodule // host_port_model

// [sim/tb_top.sv]
// Self-checking bench for the configuration register bank.
`timescale 1ns/1ps
module tb_top;
  import bl_cfg_pkg::*;
  // Arbitrary identification value.
  localparam logic [7:0] IDENT = 8'h5A;
  logic i_sys_clk = 1'h0;
  logic i_srst = 1'h1;
  logic ld, wr, rd, rv, busy, sr;
  logic [7:0] addr, wd, rdat;
  cfg_t cfg;
  cfg_t exp;
  cfg_t dflt = '{MODE_STANDBY, 1'h0, 1'h0, 5'h13, 1'h1, 1'h1, 1'h1, 2'h0,
    1'h1, 3'h3, 2'h2, 1'h0, 1'h0, 3'h0, 11'h7FF, 2'h2, 1'h0, 3'h4, 2'h3,
    4'h4, 4'h4, 3'h0, 4'h0};
  int fail_count = 0;
  int checked = 0;
  initial forever #2 i_sys_clk = ~i_sys_clk;
  backlight_config_registers #(.IDENTIFICATION_BYTE(IDENT), .QUIET_CYCLES(16))
    backlight_config_registers_inst (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
    .i_addr_load(ld), .i_addr(addr), .i_wr_stb(wr), .i_wdata(wd),
    .i_rd_stb(rd), .o_rdata(rdat), .o_rd_valid(rv), .o_busy(busy),
    .o_soft_reset(sr), .o_cfg(cfg));
  host_port_model host_port_model_inst (.i_clk(i_sys_clk), .i_busy(busy),
    .i_rd_valid(rv), .i_rdata(rdat), .o_load(ld), .o_addr(addr), .o_wr(wr),
    .o_wdata(wd), .o_rd(rd));
  task automatic cmp8(input logic [7:0] got, want);
    checked++;
    if (got !== want) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic cmp_cfg(input cfg_t want);
    @(posedge i_sys_clk);
    #1;
    checked++;
    if (cfg !== want) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, cfg, want);
    end
  endtask
  task automatic put(input logic [7:0] a, d, input int n);
    host_port_model_inst.cmd(3'h4, a, 8'h00);
    repeat (n) host_port_model_inst.cmd(3'h2, 8'h00, d);
    host_port_model_inst.cmd(3'h0, 8'h00, 8'h00);
  endtask
  task automatic get(input logic [7:0] a, input logic [7:0] want[$]);
    host_port_model_inst.rq.delete();
    host_port_model_inst.cmd(3'h4, a, 8'h00);
    repeat (want.size()) host_port_model_inst.cmd(3'h1, 8'h00, 8'h00);
    host_port_model_inst.cmd(3'h0, 8'h00, 8'h00);
    @(posedge i_sys_clk);
    #1;
    foreach (want[i]) cmp8((host_port_model_inst.rq.size() > 0) ?
      host_port_model_inst.rq.pop_front() : 8'hXX, want[i]);
  endtask
  task automatic wait_busy(input logic v);
    for (int i = 0; i < 40 && busy !== v; i++) @(negedge i_sys_clk);
    cmp8({7'h00, busy}, {7'h00, v});
  endtask
  task automatic t_defaults();
    get(8'h00, '{IDENT, RST_SOFTWARE_RESET, RST_OPERATING_MODE_CONTROL,
      RST_STRING_CURRENT_ENABLE, RST_BOOST_CONTROL_PRIMARY,
      RST_BOOST_CONTROL_SECONDARY, RST_BRIGHTNESS_LOW_BITS,
      RST_BRIGHTNESS_HIGH_BITS, RST_PULSE_INPUT_CONTROL,
      RST_SINK_ON_OFF_RAMP, RST_DIMMING_TRANSITION_RAMP});
    cmp_cfg(dflt);
  endtask
  task automatic t_modes();
    op_mode_t m[4] = '{MODE_STANDBY, MODE_BACKLIGHT, MODE_FLASH, MODE_FLASH};
    exp = dflt;
    for (int i = 0; i < 4; i++) begin
      put(8'h02, 8'(i), 1);
      exp.operating_mode_field = m[i];
      cmp_cfg(exp);
    end
  endtask
  task automatic t_write_all();
    put(8'h00, 8'h00, 1);
    put(8'h02, 8'hFF, 9);
    put(8'h0B, 8'h55, 1);
    get(8'h0B, '{8'h00});
    get(8'h00, '{IDENT, 8'h00, WM_OPERATING_MODE_CONTROL, WM_FULL, WM_FULL,
      WM_BOOST_CONTROL_SECONDARY, WM_FULL, WM_FULL, WM_FULL, WM_FULL,
      WM_DIMMING_TRANSITION_RAMP, 8'h00});
    exp = '1;
    exp.operating_mode_field = MODE_FLASH;
    cmp_cfg(exp);
    put(8'h06, 8'hFA, 1);
    put(8'h07, 8'h5C, 1);
    exp.brightness = 11'h2E2;
    cmp_cfg(exp);
  endtask
  task automatic t_soft();
    put(8'h07, 8'h11, 1);
    put(8'h01, 8'h00, 1);
    cmp8({7'h00, sr}, 8'h00);
    get(8'h07, '{8'h11});
    host_port_model_inst.cmd(3'h4, 8'h01, 8'h00);
    host_port_model_inst.cmd(3'h2, 8'h00, 8'h01);
    host_port_model_inst.cmd(3'h0, 8'h00, 8'h00);
    cmp8({7'h00, sr}, 8'h01);
    wait_busy(1'h1);
    host_port_model_inst.polite = 1'h0;
    host_port_model_inst.rq.delete();
    put(8'h07, 8'h22, 1);
    host_port_model_inst.cmd(3'h4, 8'h07, 8'h00);
    host_port_model_inst.cmd(3'h1, 8'h00, 8'h00);
    host_port_model_inst.cmd(3'h0, 8'h00, 8'h00);
    host_port_model_inst.polite = 1'h1;
    wait_busy(1'h0);
    cmp8(8'(host_port_model_inst.rq.size()), 8'h00);
    get(8'h07, '{RST_BRIGHTNESS_HIGH_BITS});
    get(8'h01, '{8'h00});
    cmp_cfg(dflt);
  endtask
  task automatic finish_test();
    if (fail_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge i_sys_clk);
    i_srst = 1'h0;
    t_defaults();
    t_modes();
    t_write_all();
    t_soft();
    finish_test();
  end
  initial begin
    #20000;
    fail_count++;
    finish_test();
  end
endmodule // tb_top
